// ### sim/bls_boot_seq_chk.sv
`timescale 1ns/100ps
module bls_boot_seq_chk #(
   parameter int FIXED_CYCLES    = 20,
   parameter int PER_BYTE_CYCLES = 2,
   parameter int USER_BYTES      = 8
) (
   input wire logic                  ref_clk,
   input wire logic                  srst,
   input wire logic [12:0]           nvmAddr_r,
   input wire bls_pkg::bls_ram_req_t ramReq_r,
   input wire bls_pkg::bls_sys_t     sys_r,
   input wire logic [7:0]            portLatch_r,
   input wire logic                  intOscSel_r,
   input wire logic [15:0]           cpuPc_r,
   input wire logic                  hsel,
   input wire logic [31:0]           haddr,
   input wire logic [1:0]            htrans,
   input wire logic                  hwrite,
   input wire logic                  hready,
   input wire logic [31:0]           hrdata_r
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (srst);
   logic [19:0] sinceRst;
   always_ff @(posedge ref_clk) begin
      if (srst) sinceRst <= 20'h00000;
      else if (sinceRst != 20'hfffff) sinceRst <= sinceRst + 20'h00001;
   end
   chk_port_ones: assert property (portLatch_r == 8'hff)
      else $error("port latches not all ones");
   chk_osc_internal: assert property (intOscSel_r)
      else $error("internal oscillator not selected");
   chk_reset_halts: assert property (disable iff (1'b0) srst |=>
      !sys_r.cpuRun && sys_r.portOpenDrain && cpuPc_r == 16'h0000)
      else $error("reset did not halt the core");
   chk_jump_entry: assert property ($rose(sys_r.cpuRun) |->
      cpuPc_r == 16'h0000) else $error("run began away from entry");
   chk_run_holds: assert property (sys_r.cpuRun |=> sys_r.cpuRun)
      else $error("core stopped without reset");
   chk_copy_first: assert property (sys_r.cpuRun |-> !ramReq_r.req)
      else $error("RAM written while running");
   chk_ram_bounds: assert property (ramReq_r.req |->
      ramReq_r.write && ramReq_r.addr <= 13'h11ff)
      else $error("RAM request outside RAM");
   chk_fixed_delay: assert property (ramReq_r.req &&
      ramReq_r.addr < 13'h11e3 |-> sinceRst >= FIXED_CYCLES)
      else $error("user copy began too early");
   chk_prog_gate: assert property (sys_r.nvmProgAllow |->
      sys_r.debugEnable) else $error("programming open at run level");
   chk_lock_window: assert property (hsel && hready && htrans[1] &&
      !hwrite && haddr == 32'h00000014 |=> hrdata_r == 32'he000ffff)
      else $error("NVM window value wrong");
   cover property ($rose(sys_r.cpuRun));
   cover property (sys_r.nvmProgAllow);
   cover property (sys_r.debugEnable && !sys_r.cpuRun);
endmodule // bls_boot_seq_chk

bind bls_boot_seq bls_boot_seq_chk #(.FIXED_CYCLES(FIXED_CYCLES),
   .PER_BYTE_CYCLES(PER_BYTE_CYCLES), .USER_BYTES(USER_BYTES))
   bls_boot_seq_chk_inst (.ref_clk(ref_clk), .srst(srst),
   .nvmAddr_r(nvmAddr_r), .ramReq_r(ramReq_r), .sys_r(sys_r),
   .portLatch_r(portLatch_r), .intOscSel_r(intOscSel_r), .cpuPc_r(cpuPc_r),
   .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
   .hready(hready), .hrdata_r(hrdata_r));

// ### sim/bls_nvm_model.sv
`timescale 1ns/100ps
module bls_nvm_model (
   input  wire logic        ref_clk,
   input  wire logic [12:0] nvmAddr,
   input  wire logic [2:0]  level,
   input  wire logic [7:0]  prot,
   output logic      [7:0]  nvmRdata
);
   // A byte answers one cycle after its address, as the array does.
   // The user load starts at 0x100 and each byte is derived from its address.
   always_ff @(posedge ref_clk) begin
      case (nvmAddr)
         13'h0000: nvmRdata <= {5'h00, level};
         13'h0001: nvmRdata <= prot;
         13'h0002: nvmRdata <= 8'h01;
         default:  nvmRdata <= nvmAddr[7:0] ^ 8'h5a;
      endcase
   end
endmodule // bls_nvm_model

// ### sim/boot_load_sequencer_tb_top.sv
`timescale 1ns/100ps
module boot_load_sequencer_tb_top;
   logic ref_clk = 1'b0, srst = 1'b1, porEvent = 1'b1, hsel = 1'b0;
   logic hwrite = 1'b0;
   logic [1:0] htrans = 2'b00;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata_r;
   logic [7:0] nvmRdata, portLatch_r, prot = 8'h00;
   logic [2:0] level = 3'h1;
   logic [12:0] nvmAddr_r;
   logic [15:0] cpuPc_r;
   logic intOscSel_r, hreadyout_r, hresp_r;
   bls_pkg::bls_ram_req_t ramReq_r;
   bls_pkg::bls_sys_t sys_r;
   int failures = 0, total_checks = 0, cyc = 0, t0, tEnd, userWrites;
   int statSeen;
   always #2.5 ref_clk = ~ref_clk;
   always @(posedge ref_clk) cyc++;
   bls_boot_seq #(.FIXED_CYCLES(40), .PER_BYTE_CYCLES(2), .USER_BYTES(8))
      bls_boot_seq_inst (.ref_clk(ref_clk), .srst(srst),
      .porEvent(porEvent), .nvmRdata(nvmRdata), .nvmAddr_r(nvmAddr_r),
      .ramReq_r(ramReq_r), .sys_r(sys_r), .portLatch_r(portLatch_r),
      .intOscSel_r(intOscSel_r), .cpuPc_r(cpuPc_r), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
      .hwdata(hwdata), .hready(hreadyout_r), .hrdata_r(hrdata_r),
      .hreadyout_r(hreadyout_r), .hresp_r(hresp_r));
   bls_nvm_model bls_nvm_model_inst (.ref_clk(ref_clk),
      .nvmAddr(nvmAddr_r), .level(level), .prot(prot), .nvmRdata(nvmRdata));
   ////////////////////////////////////////////////////////////////////////
   task automatic chk(input string nm, input logic [31:0] e, g);
      total_checks++;
      if (g !== e) begin
         failures++;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic conclude;
      if (failures == 0 && total_checks > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   // The address phase is held until hready is seen high, then the data.
   task automatic bus(input logic w, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] q);
      @(posedge ref_clk);
      hsel <= 1'b1; htrans <= 2'b10; hwrite <= w; haddr <= {24'h0, a};
      do @(posedge ref_clk); while (hreadyout_r !== 1'b1);
      hsel <= 1'b0; htrans <= 2'b00; hwdata <= d;
      do @(posedge ref_clk); while (hreadyout_r !== 1'b1);
      q = hrdata_r;
   endtask
   task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] e);
      logic [31:0] q;
      bus(1'b0, a, 32'h0, q);
      chk(nm, e, q);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      bus(1'b1, a, d, q);
      repeat (3) @(posedge ref_clk);
   endtask
   task automatic boot(input logic [2:0] l, input logic [7:0] p,
                       input logic por);
      level <= l; prot <= p; porEvent <= por; srst <= 1'b1;
      repeat (5) @(posedge ref_clk);
      userWrites = 0; statSeen = 0;
      srst <= 1'b0; porEvent <= 1'b0; t0 = cyc;
      do @(posedge ref_clk);
      while (sys_r.cpuRun !== 1'b1 && sys_r.debugEnable !== 1'b1
             && cyc - t0 < 500);
      tEnd = cyc;
      repeat (2) @(posedge ref_clk);
   endtask
   always @(posedge ref_clk)
      if (!srst && ramReq_r.req === 1'b1) begin
         if (ramReq_r.addr < 13'h11e3) begin
            userWrites++;
            chk("ram data", {24'h0, ramReq_r.addr[7:0] ^ 8'h5a},
                {24'h0, ramReq_r.data});
         end else if (ramReq_r.addr == bls_pkg::RAM_STAT_BEG)
            statSeen = (ramReq_r.data === bls_pkg::RESULT_OK);
      end
   ////////////////////////////////////////////////////////////////////////
   initial begin
      for (int b = 0; b < 2; b++) begin
         boot(bls_pkg::LVL_FACTORY, 8'h00, 1'b1);
         chk("short boot", 1, (tEnd - t0) < 40);
         chk("factory copies", 0, userWrites);
         chk("status block", 1, statSeen);
         rd("level", bls_pkg::ADDR_LEVEL, 32'h1);
         rd("result", bls_pkg::ADDR_RESULT, 32'h0);
         repeat (30) @(posedge ref_clk);
         chk("still waiting", 0, sys_r.cpuRun);
         wr(bls_pkg::ADDR_CTRL, 32'h1 << b);
         chk("released", 1, sys_r.cpuRun);
         chk("entry", 0, cpuPc_r);
      end
      boot(bls_pkg::LVL_USER, 8'h00, 1'b1);
      chk("user copies", 8, userWrites);
      chk("user waits", 0, sys_r.cpuRun);
      chk("user debug", 1, sys_r.debugEnable);
      rd("level", bls_pkg::ADDR_LEVEL, 32'h3);
      wr(bls_pkg::ADDR_CTRL, 32'h8);
      chk("prog open", 1, sys_r.nvmProgAllow);
      wr(bls_pkg::ADDR_CTRL, 32'h4);
      rd("trim set", bls_pkg::ADDR_CTRL, 32'h4);
      boot(bls_pkg::LVL_USER, 8'h00, 1'b0);
      chk("trim skips", 0, userWrites);
      chk("trim waits", 1, sys_r.debugEnable);
      boot(bls_pkg::LVL_USER, 8'h01, 1'b0);
      chk("trim overrides", 0, sys_r.cpuRun);
      boot(bls_pkg::LVL_USER, 8'h01, 1'b1);
      chk("cont copies", 8, userWrites);
      chk("cont runs", 1, sys_r.cpuRun);
      chk("cont debug", 1, sys_r.debugEnable);
      boot(bls_pkg::LVL_RUN, 8'h00, 1'b1);
      chk("run runs", 1, sys_r.cpuRun);
      chk("run no debug", 0, sys_r.debugEnable);
      chk("run lower", 1, (tEnd - t0) >= 40 + 8 * 2);
      chk("run upper", 1, (tEnd - t0) <= 40 + 8 * 2 + 40);
      wr(bls_pkg::ADDR_CTRL, 32'h8);
      chk("prog shut", 0, sys_r.nvmProgAllow);
      rd("window", bls_pkg::ADDR_NVMLOCK, 32'he000ffff);
      rd("unmapped", 8'h40, 32'h0);
      chk("ports", 32'hff, {24'h0, portLatch_r});
      conclude;
   end
   initial begin
      repeat (20000) @(posedge ref_clk);
      failures++;
      conclude;
   end
endmodule // boot_load_sequencer_tb_top

// ### verilog/bls_boot_seq.sv
// The register addresses and the AHB-Lite slave port are this design's own decisions.
`timescale 1ns/100ps
// Function
// [R1] Every reset copies factory then user load to RAM, then runs at 0x0000; factory level and trim skip the user copy and park in WAIT.
// [R2] Startup takes about 2 ms plus 3.6 ms per user kilobyte.
// [R3] Factory-only boot finishes in under 2 ms.
// [R4] Power-on reset, at power-up or wake, is the only external reset.
// [R5] Under reset the processor halts and control state takes reset values.
// [R6] Port latches reset to all ones, pins in open-drain mode.
// [R7] Leaving reset clears the program counter, selects internal clock, boots.
// [R8] Boot first reads factory config and branches on the program level.
// [R9] The program level is readable as a three-bit field.
// [R10] Factory level waits until either code-run bit is set.
// [R11] User level also copies the user region, then waits.
// [R12] Boot-trim set skips the user load, enables debug, waits; overrides.
// [R13] The user-continue bit is one-time settable, never cleared.
// [R14] User-continue set enables debug and jumps to 0x0000 at once.
// [R15] Run level jumps to 0x0000 with debug disabled.
// [R16] Run level refuses further NVM programming.
// [R17] User level still accepts NVM programming and debug.
// [R18] ROM and factory NVM region are never readable by software.
// [R19] NVM sits at 0xE000 to 0xFFFF, reachable only through service routines.
// [R20] The last 64 NVM bytes are reserved and never loaded.
// [R21] Boot copies only the user region, never the overlay region.
// [R22] Factory load also fills the boot status block at top of RAM.
// [R23] Software treats only 0x00 and 0x80 results as a clean boot.
// [R24] Debug host loads RAM before setting a code-run bit.
// [R25] Boot-trim stays writable while waiting and survives non-power resets.
module bls_boot_seq #(
   parameter int FIXED_CYCLES   = bls_pkg::FIXED_CYC,
   parameter int PER_BYTE_CYCLES = bls_pkg::PER_BYTE_CYC,
   parameter int USER_BYTES     = 1024
) (
   input  wire logic                ref_clk,
   input  wire logic                srst,
   input  wire logic                porEvent,
   input  wire logic [7:0]          nvmRdata,
   output logic [12:0]              nvmAddr_r,
   output bls_pkg::bls_ram_req_t    ramReq_r,
   output bls_pkg::bls_sys_t        sys_r,
   output logic [7:0]               portLatch_r,
   output logic                     intOscSel_r,
   output logic [15:0]              cpuPc_r,
   input  wire logic                hsel,
   input  wire logic [31:0]         haddr,
   input  wire logic [1:0]          htrans,
   input  wire logic                hwrite,
   input  wire logic [2:0]          hsize,
   input  wire logic [31:0]         hwdata,
   input  wire logic                hready,
   output logic [31:0]              hrdata_r,
   output logic                     hreadyout_r,
   output logic                     hresp_r
);

   typedef enum logic [6:0] {
      ST_CFG   = 7'h01,
      ST_FACT  = 7'h02,
      ST_STAT  = 7'h04,
      ST_USER  = 7'h08,
      ST_WAIT  = 7'h10,
      ST_JUMP  = 7'h20,
      ST_RUN   = 7'h40
   } bls_state_t;

   bls_state_t  state_r;
   logic [31:0] cnt_r;
   logic [12:0] idx_r;
   logic [2:0]  level_r;
   logic        userCont_r;
   logic        trim_r;
   logic        runPor_r;
   logic        runSys_r;
   logic        progReq_r;
   logic        bootBad_r;
   logic        porMeta_r;
   logic        porSync_r;
   logic        porSeen_r;
   logic [12:0] userBeg_r;
   logic        aphValid_r;
   logic        aphWrite_r;
   logic [7:0]  aphAddr_r;

   ////////////////////////////////////////////////////////////////////////////
   // Flow of one boot, from the release of reset to the first instruction.
   // CFG reads three bytes of the protected area, one per cycle: the program
   // level, the protection byte that carries the autorun bit and the high
   // part of the user start address. The array answers one cycle after its
   // address, so every byte is taken one step after the address was issued.
   // FACT copies the factory values into the reserved area that lies just
   // below the status block. STAT writes the result byte last, so software
   // that finds it written also finds the rest of the block complete.
   // From STAT the sequencer either parks in WAIT (factory level, or the
   // trim flag set) or goes on to USER, which paces the user copy.
   // After USER, run level and the autorun bit lead straight to JUMP; any
   // other user level parks in WAIT like a blank part.
   // WAIT is left only when one of the two run bits is written to one.
   // JUMP loads the entry address and lets the core run for good; only a
   // new reset brings the sequencer back to CFG.
   // The trade-off here is a strictly serial copy: one byte at a time keeps
   // the array interface trivial, at the price of a long startup that grows
   // with the size of the user load.
   // An unknown level code still boots as a user part, copying the user load, but marks the
   // result byte bad, so software can refuse to run on such a part.

   // Length of the user copy, clipped so the reserved tail stays untouched.
   function automatic logic [12:0] userLimit(input logic [12:0] beg);
      int lim;
      lim = bls_pkg::NVM_BYTES - bls_pkg::NVM_RSVD - int'(beg);
      if (lim > USER_BYTES)
         lim = USER_BYTES;
      if (lim < 0)
         lim = 0;
      return lim[12:0]; // see [R20]
   endfunction

   wire logic        copyTick = (cnt_r == 32'h0);
   wire logic        runBit   = runPor_r | runSys_r;
   wire logic        aphTake  = hsel & hready & htrans[1];

   ////////////////////////////////////////////////////////////////////////////
   // Power-on indication: synchronised, it marks a true power cycle.
   // The pin is raised together with reset, so the two flip-flops must keep
   // sampling while reset is held: a synchroniser cleared by reset would
   // never see the pulse and the trim flag would never be cleared.
   // Only the second stage is read by any logic.
   always_ff @(posedge ref_clk) begin
      porMeta_r <= porEvent;
      porSync_r <= porMeta_r;
   end

   // The trim flag is cleared by a power cycle or by a zero written while parked, so a
   // debug reset keeps the factory-like behaviour until one of those happens.
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         porSeen_r <= 1'b0;
      end else begin
         porSeen_r <= porSync_r;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (porSync_r & ~porSeen_r) begin
         trim_r <= 1'b0; // see [R12] see [R25]
      end else if (aphValid_r & aphWrite_r & (aphAddr_r ==
                   bls_pkg::ADDR_CTRL) & (state_r == ST_WAIT)) begin
         trim_r <= hwdata[bls_pkg::CTRL_TRIM_BIT]; // see [R25]
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Boot sequencer.
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         state_r    <= ST_CFG; // see [R4] see [R7]
         cnt_r      <= 32'h0;
         idx_r      <= 13'h0;
         nvmAddr_r  <= bls_pkg::NVM_CFG_ADDR;
         level_r    <= bls_pkg::LVL_FACTORY;
         userCont_r <= 1'b0;
         userBeg_r  <= 13'h0;
         ramReq_r   <= '0;
         bootBad_r  <= 1'b0;
      end else begin
         ramReq_r <= '0;
         unique case (state_r)
            ST_CFG: begin
               // Config, protection byte and user start, one per cycle.
               idx_r     <= idx_r + 13'h1;
               nvmAddr_r <= idx_r + 13'h1;
               if (idx_r == bls_pkg::NVM_CFG_ADDR + 13'h1)
                  level_r <= nvmRdata[2:0]; // see [R8]
               if (idx_r == bls_pkg::NVM_PROT_ADDR + 13'h1)
                  userCont_r <= userCont_r |
                     nvmRdata[bls_pkg::AUTORUN_USER_BIT_BIT]; // see [R13]
               if (idx_r == bls_pkg::NVM_UBEG_ADDR + 13'h1) begin
                  userBeg_r <= {nvmRdata[4:0], 8'h00};
                  if (!(level_r inside {bls_pkg::LVL_FACTORY,
                        bls_pkg::LVL_USER, bls_pkg::LVL_RUN}))
                     bootBad_r <= 1'b1;
                  idx_r     <= 13'h0;
                  state_r   <= ST_FACT;
               end
            end
            ST_FACT: begin
               // Factory values go to the reserved area below the status block.
               ramReq_r <= '{req: 1'b1, write: 1'b1,
                  addr: bls_pkg::RAM_STAT_BEG - 13'(bls_pkg::FACT_BYTES)
                        + idx_r, data: nvmRdata}; // see [R1]
               nvmAddr_r <= bls_pkg::NVM_UBEG_ADDR + 13'h1 + idx_r;
               idx_r <= idx_r + 13'h1;
               if (idx_r == 13'(bls_pkg::FACT_BYTES - 1)) begin
                  idx_r   <= 13'h0;
                  state_r <= ST_STAT;
               end
            end
            ST_STAT: begin
               // Result byte written last into the status block.
               ramReq_r <= '{req: 1'b1, write: 1'b1,
                  addr: bls_pkg::RAM_STAT_BEG,
                  data: bootBad_r ? bls_pkg::RESULT_BAD
                                  : bls_pkg::RESULT_OK}; // see [R22]
               cnt_r     <= FIXED_CYCLES - 2;
               nvmAddr_r <= userBeg_r;
               if (level_r == bls_pkg::LVL_FACTORY || trim_r) begin
                  state_r <= ST_WAIT; // see [R10] see [R12] see [R3]
               end else begin
                  state_r <= ST_USER; // see [R11]
               end
            end
            ST_USER: begin
               // The counter was loaded in STAT, so the fixed part of the
               // startup time runs out before the first user byte moves.
               // Each byte then costs a fixed number of cycles; the pace is
               // a parameter so that a bench can shrink it.
               // The copy length is clipped so that the reserved tail of
               // the array is never read into RAM, whatever start address
               // the protected area holds.
               // Only the user region is copied; an overlay region behind
               // it is left for the application to fetch later.
               // Paced copy: the fixed wait runs first, then one byte per
               // slot, giving the documented per-kilobyte cost.
               if (copyTick) begin
                  if (idx_r == userLimit(userBeg_r)) begin // see [R21]
                     idx_r   <= 13'h0;
                     if (level_r == bls_pkg::LVL_RUN || userCont_r)
                        state_r <= ST_JUMP; // see [R14] see [R15]
                     else
                        state_r <= ST_WAIT; // see [R11]
                  end else begin
                     ramReq_r <= '{req: 1'b1, write: 1'b1,
                        addr: bls_pkg::RAM_ENTRY + idx_r,
                        data: nvmRdata}; // see [R1]
                     idx_r     <= idx_r + 13'h1;
                     nvmAddr_r <= userBeg_r + idx_r + 13'h1;
                     cnt_r     <= PER_BYTE_CYCLES - 1; // see [R2]
                  end
               end else begin
                  cnt_r <= cnt_r - 32'h1;
               end
            end
            ST_WAIT: begin
               if (runBit)
                  state_r <= ST_JUMP; // see [R10] see [R24]
            end
            ST_JUMP: begin
               state_r <= ST_RUN;
            end
            ST_RUN: begin
               state_r <= ST_RUN;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // System outputs seen by the core and the pads.
   // Ports stay at all ones in open-drain mode for the whole boot, so no
   // pin drives before the application takes over.
   // The debug port opens as soon as the sequencer parks or jumps, except
   // at run level, where it stays shut for good.
   // Programming of the array is only offered while parked or running at a
   // level below run, so a finished part can never be written again.
   // The core is held until JUMP; its program counter is the entry address
   // from reset onwards and is loaded again at the jump.
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         portLatch_r <= bls_pkg::PORT_RESET; // see [R6]
         sys_r       <= '{portOpenDrain: 1'b1, debugEnable: 1'b0,
                          cpuRun: 1'b0, nvmProgAllow: 1'b0}; // see [R5] see [R6]
         intOscSel_r <= 1'b1; // see [R7]
         cpuPc_r     <= 16'h0000; // see [R7]
      end else begin
         portLatch_r <= bls_pkg::PORT_RESET;
         intOscSel_r <= 1'b1;
         sys_r.portOpenDrain <= 1'b1;
         sys_r.debugEnable   <= (state_r inside {ST_WAIT, ST_JUMP, ST_RUN})
                                && level_r != bls_pkg::LVL_RUN; // see [R15]
         sys_r.nvmProgAllow  <= progReq_r && level_r != bls_pkg::LVL_RUN
                                && state_r inside {ST_WAIT, ST_RUN}; // see [R16] see [R17]
         if (state_r == ST_JUMP) begin
            sys_r.cpuRun <= 1'b1;
            cpuPc_r      <= {3'h0, bls_pkg::RAM_ENTRY}; // see [R1] see [R14]
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // AHB-Lite slave, zero wait states, always OKAY.
   // The address phase is captured at the edge where it is taken; the write
   // data follow one cycle later and are applied at the next edge.
   // Reads are answered from the address phase, so the data stand in the
   // data phase without any wait state.
   // Transfer size is not decoded: every register is one whole word, and a
   // narrower access simply sees or writes the whole word.
   // Unmapped offsets read as zero and ignore writes.
   // There is no error response; a master never has to handle one.
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         aphValid_r  <= 1'b0;
         aphWrite_r  <= 1'b0;
         aphAddr_r   <= 8'h00;
         hreadyout_r <= 1'b1;
         hresp_r     <= 1'b0;
      end else begin
         aphValid_r <= aphTake;
         aphWrite_r <= hwrite;
         aphAddr_r  <= haddr[7:0];
      end
   end

   // The run bits release the parked sequencer at once, so a debug host has
   // to place its image in RAM before it writes either of them.
   // They are cleared by every reset, so each boot that parks stays there until a new
   // write arrives.
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         runPor_r  <= 1'b0;
         runSys_r  <= 1'b0;
         progReq_r <= 1'b0;
      end else if (aphValid_r & aphWrite_r
                   & aphAddr_r == bls_pkg::ADDR_CTRL) begin
         runPor_r  <= hwdata[bls_pkg::CTRL_RUN_POR_BIT];
         runSys_r  <= hwdata[bls_pkg::CTRL_RUN_SYS_BIT];
         progReq_r <= hwdata[bls_pkg::CTRL_PROG_REQ_BIT];
      end
   end

   // Read data is registered at the address phase edge; no path leads to
   // NVM contents or ROM, so software never sees them.
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         hrdata_r <= 32'h0;
      end else if (aphTake & ~hwrite) begin
         unique case (haddr[7:0])
            bls_pkg::ADDR_CTRL:
               hrdata_r <= {28'h0, progReq_r, trim_r, runSys_r, runPor_r};
            bls_pkg::ADDR_STATUS:
               hrdata_r <= {21'h0, sys_r, state_r};
            bls_pkg::ADDR_LEVEL:
               hrdata_r <= {28'h0, userCont_r, level_r}; // see [R9]
            bls_pkg::ADDR_RESULT:
               hrdata_r <= {24'h0, bootBad_r ? bls_pkg::RESULT_BAD
                                             : bls_pkg::RESULT_OK};
            bls_pkg::ADDR_PC:
               hrdata_r <= {16'h0, cpuPc_r};
            bls_pkg::ADDR_NVMLOCK:
               hrdata_r <= {bls_pkg::NVM_WIN_BASE,
                            bls_pkg::NVM_WIN_LAST}; // see [R18] see [R19]
            default:
               hrdata_r <= 32'h0;
         endcase
      end
   end

endmodule // bls_boot_seq

// ### verilog/bls_pkg.sv
package bls_pkg;

   // Register map, byte addresses on the AHB-Lite slave.
   localparam logic [7:0] ADDR_CTRL    = 8'h00;
   localparam logic [7:0] ADDR_STATUS  = 8'h04;
   localparam logic [7:0] ADDR_LEVEL   = 8'h08;
   localparam logic [7:0] ADDR_RESULT  = 8'h0c;
   localparam logic [7:0] ADDR_PC      = 8'h10;
   localparam logic [7:0] ADDR_NVMLOCK = 8'h14;

   // Control register fields.
   localparam int CTRL_RUN_POR_BIT  = 0;
   localparam int CTRL_RUN_SYS_BIT  = 1;
   localparam int CTRL_TRIM_BIT     = 2;
   localparam int CTRL_PROG_REQ_BIT = 3;

   // Program level encodings in the three-bit level field.
   localparam logic [2:0] LVL_FACTORY = 3'h1;
   localparam logic [2:0] LVL_USER    = 3'h3;
   localparam logic [2:0] LVL_RUN     = 3'h7;

   // NVM geometry.
   localparam logic [15:0] NVM_WIN_BASE  = 16'he000;
   localparam logic [15:0] NVM_WIN_LAST  = 16'hffff;
   localparam int          NVM_BYTES     = 8192;
   localparam int          NVM_RSVD      = 64;
   localparam logic [12:0] NVM_CFG_ADDR  = 13'h0000;
   localparam logic [12:0] NVM_PROT_ADDR = 13'h0001;
   localparam logic [12:0] NVM_UBEG_ADDR = 13'h0002;
   localparam int          AUTORUN_USER_BIT_BIT = 0;

   // RAM layout.
   localparam logic [12:0] RAM_ENTRY    = 13'h0000;
   localparam logic [12:0] RAM_STAT_BEG = 13'h11f3;
   localparam logic [7:0]  RESULT_OK    = 8'h00;
   localparam logic [7:0]  RESULT_BAD   = 8'h01;

   // Port latches reset to all ones.
   localparam logic [7:0] PORT_RESET = 8'hff;

   // Startup timing, in ns and derived cycles at 200 MHz.
   localparam int CLK_NS        = 5;
   localparam int FIXED_NS      = 2000000;
   localparam int PER_KB_NS     = 3600000;
   localparam int FIXED_CYC     = FIXED_NS / CLK_NS;
   localparam int PER_KB_CYC    = PER_KB_NS / CLK_NS;
   localparam int PER_BYTE_CYC  = PER_KB_CYC / 1024;
   localparam int FACT_BYTES    = 16;

   typedef struct packed {
      logic        req;
      logic        write;
      logic [12:0] addr;
      logic [7:0]  data;
   } bls_ram_req_t;

   typedef struct packed {
      logic        portOpenDrain;
      logic        debugEnable;
      logic        cpuRun;
      logic        nvmProgAllow;
   } bls_sys_t;

endpackage
